//--- hw/fwp_core.sv
// fwp_core: status/function register protection logic of the serial flash
// assumes instruction strobes are one-cycle pulses already decoded, synchronous to clk_i
//
// Summary of operation
// - chip erase accepted only when all four protect bits are zero
// - status write disable clear: status writable whatever the protect pin
// - disable set and pin low: protect, quad, disable bits read-only
// - disable set and pin high: status write accepted
// - quad enable 0 gives pins to protect/hold; 1 enables data lanes and frees hold of reset, protect pin still gates status writes
// - standard map, top: code n protects highest 2^(n-1) blocks
// - standard map: protect msb set protects all 128 blocks
// - bottom select places the same counts from block 0 upward
// - optional map: codes 8..13 give 96..127 blocks, 14,15 all
// - function register eight bits: reset disable, bottom, suspends, four locks
// - one-time bits once 1 never return to 0
// - reset disable default strapped; 1 moves reset to shared hold pin while quad enable is 0
// - bottom select defaults top; once bottom it stays bottom
// - program suspended flag set on suspend in program, cleared on resume
// - erase suspended flag set on suspend in erase, cleared on resume
// - info row lock defaults 0; once 1 that row's programming blocked
// - program or erase into a protected block is inhibited
// - status layout disable, quad, four protect, latch, busy; reset zero
// - protect, quad, disable change only by status write after unlock
`timescale 1ns/1ns
module fwp_core
   import fwp_pkg::*;
#(
   parameter logic RSTDIS_DEFAULT = 1'b0,
   parameter logic OPTIONAL_MAP = 1'b0
)
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic write_unlock_cmd_i,
   input wire logic write_lock_cmd_i,
   input wire logic write_status_cmd_i,
   input wire logic [7:0] status_data_i,
   input wire logic write_function_cmd_i,
   input wire logic [7:0] function_data_i,
   input wire logic write_protect_pin_i,
   input wire logic whole_array_erase_cmd_i,
   input wire logic array_op_cmd_i,
   input wire logic array_op_is_erase_i,
   input wire logic [BLOCK_IDX_W-1:0] array_op_first_block_i,
   input wire logic [BLOCK_IDX_W-1:0] array_op_last_block_i,
   input wire logic info_row_prog_cmd_i,
   input wire logic [1:0] info_row_sel_i,
   input wire logic op_done_i,
   input wire logic suspend_cmd_i,
   input wire logic resume_cmd_i,
   output logic [7:0] status_reg_o,
   output logic [7:0] function_config_o,
   output logic op_start_o,
   output logic op_rejected_o,
   output logic quad_lane_enable_o,
   output logic reset_on_hold_pin_o,
   output logic [BLOCK_IDX_W:0] protect_count_o,
   output logic protect_bottom_o
);
   typedef enum logic [1:0] {FWP_IDLE, FWP_PROGRAM, FWP_ERASE} fwp_op_t;

   fwp_op_t op_q;
   logic wdis_q, quad_q, unlock_q, busy_q;
   logic [3:0] bp_q;
   logic [7:0] fr_otp_q;
   logic prog_susp_q, erase_susp_q;
   logic wp_sampled;
   logic sr_locked;
   logic [7:0] cnt_d;
   logic [7:0] lo_bound, hi_bound;
   logic range_hit;
   logic erase_ok, array_ok, irow_ok, status_ok, func_ok;
   logic rstdis_strap_q;
   logic strap_taken_q;

   // protected block count from the protect code
   always_comb
   begin
      cnt_d = 8'h00;
      if (bp_q[3] && !OPTIONAL_MAP)
      begin
         cnt_d = ALL_CNT;
      end
      else if (bp_q[3])
      begin
         case (bp_q[2:0])
            3'd0: cnt_d = OPT_CNT_8;
            3'd1: cnt_d = OPT_CNT_9;
            3'd2: cnt_d = OPT_CNT_10;
            3'd3: cnt_d = OPT_CNT_11;
            3'd4: cnt_d = OPT_CNT_12;
            3'd5: cnt_d = OPT_CNT_13;
            default: cnt_d = ALL_CNT;
         endcase
      end
      else if (bp_q != 4'h0)
      begin
         cnt_d = 8'h01 << (bp_q[2:0] - 3'd1);
      end
   end

   // protected window as [lo, hi), widened to 8 bits so 128 fits
   always_comb
   begin
      if (fr_otp_q[FR_BOTTOM_POS])
      begin
         lo_bound = 8'h00;
         hi_bound = cnt_d;
      end
      else
      begin
         lo_bound = ALL_CNT - cnt_d;
         hi_bound = ALL_CNT;
      end
   end

   // any overlap of the requested block span with the protected window
   assign range_hit = (cnt_d != 8'h00)
      && ({1'b0, array_op_last_block_i} >= lo_bound)
      && ({1'b0, array_op_first_block_i} < hi_bound);

   // pin level taken in the cycle the status write arrives
   assign wp_sampled = write_protect_pin_i;
   assign sr_locked = wdis_q && !wp_sampled;
   assign status_ok = write_status_cmd_i && unlock_q && !busy_q && !sr_locked;
   assign func_ok = write_function_cmd_i && unlock_q && !busy_q;
   assign erase_ok = whole_array_erase_cmd_i && unlock_q && !busy_q && (bp_q == 4'h0);
   assign array_ok = array_op_cmd_i && unlock_q && !busy_q && !range_hit;
   assign irow_ok = info_row_prog_cmd_i && unlock_q && !busy_q
      && !fr_otp_q[FR_IRL_LSB + 32'(info_row_sel_i)];

   // status bits: only a permitted status write alters them
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         wdis_q <= SR_RESET[SR_WDIS_POS];
         quad_q <= SR_RESET[SR_QUAD_POS];
         bp_q <= SR_RESET[SR_BP_LSB +: 4];
      end
      else if (status_ok)
      begin
         wdis_q <= status_data_i[SR_WDIS_POS];
         quad_q <= status_data_i[SR_QUAD_POS];
         bp_q <= status_data_i[SR_BP_LSB +: 4];
      end
   end

   // write unlock latch and busy flag
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         unlock_q <= 1'b0;
         busy_q <= 1'b0;
      end
      else
      begin
         if (status_ok || func_ok || erase_ok || array_ok || irow_ok)
         begin
            busy_q <= 1'b1;
            unlock_q <= 1'b0;
         end
         else if (op_done_i && busy_q)
         begin
            busy_q <= 1'b0;
         end
         else if (write_lock_cmd_i && !busy_q)
         begin
            unlock_q <= 1'b0;
         end
         else if (write_unlock_cmd_i && !busy_q)
         begin
            unlock_q <= 1'b1;
         end
      end
   end

   // strap for the reset disable default is caught after reset release
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         strap_taken_q <= 1'b0;
         rstdis_strap_q <= 1'b0;
      end
      else if (!strap_taken_q)
      begin
         strap_taken_q <= 1'b1;
         rstdis_strap_q <= RSTDIS_DEFAULT;
      end
   end

   // one-time bits can only be ored, never cleared by software
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         fr_otp_q <= FR_RESET;
      end
      else
      begin
         if (!strap_taken_q)
         begin
            fr_otp_q[FR_RSTDIS_POS] <= fr_otp_q[FR_RSTDIS_POS] | RSTDIS_DEFAULT;
         end
         else if (func_ok)
         begin
            fr_otp_q <= fr_otp_q | (function_data_i & FR_OTP_MASK);
         end
      end
   end

   // operation tracker and suspend flags
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         op_q <= FWP_IDLE;
         prog_susp_q <= 1'b0;
         erase_susp_q <= 1'b0;
      end
      else
      begin
         case (op_q)
            FWP_IDLE:
            begin
               if (erase_ok || (array_ok && array_op_is_erase_i))
               begin
                  op_q <= FWP_ERASE;
               end
               else if (array_ok || irow_ok)
               begin
                  op_q <= FWP_PROGRAM;
               end
            end
            FWP_PROGRAM:
            begin
               if (suspend_cmd_i && !prog_susp_q)
               begin
                  prog_susp_q <= 1'b1;
               end
               else if (resume_cmd_i && prog_susp_q)
               begin
                  prog_susp_q <= 1'b0;
               end
               else if (op_done_i && !prog_susp_q)
               begin
                  op_q <= FWP_IDLE;
               end
            end
            default:
            begin
               if (suspend_cmd_i && !erase_susp_q)
               begin
                  erase_susp_q <= 1'b1;
               end
               else if (resume_cmd_i && erase_susp_q)
               begin
                  erase_susp_q <= 1'b0;
               end
               else if (op_done_i && !erase_susp_q)
               begin
                  op_q <= FWP_IDLE;
               end
            end
         endcase
      end
   end

   // registered outputs
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         status_reg_o <= SR_RESET;
         function_config_o <= FR_RESET;
         op_start_o <= 1'b0;
         op_rejected_o <= 1'b0;
         quad_lane_enable_o <= 1'b0;
         reset_on_hold_pin_o <= 1'b0;
         protect_count_o <= '0;
         protect_bottom_o <= 1'b0;
      end
      else
      begin
         status_reg_o <= {wdis_q, quad_q, bp_q, unlock_q, busy_q};
         function_config_o <= {fr_otp_q[7:4], erase_susp_q, prog_susp_q, fr_otp_q[1:0]};
         op_start_o <= erase_ok || array_ok || irow_ok;
         op_rejected_o <= (whole_array_erase_cmd_i && !erase_ok)
            || (array_op_cmd_i && !array_ok)
            || (info_row_prog_cmd_i && !irow_ok)
            || (write_status_cmd_i && !status_ok);
         quad_lane_enable_o <= quad_q;
         // shared pin only carries reset while it is not a data lane
         reset_on_hold_pin_o <= fr_otp_q[FR_RSTDIS_POS] && !quad_q;
         protect_count_o <= cnt_d;
         protect_bottom_o <= fr_otp_q[FR_BOTTOM_POS];
      end
   end

   logic unused_ok;
   assign unused_ok = rstdis_strap_q;
endmodule

//--- hw/fwp_pkg.sv
// fwp_pkg: constants for the flash write-protect and function register block
// assumes a decoded instruction stream from the serial front end of the device
package fwp_pkg;
   localparam int unsigned BLOCK_COUNT = 128;
   localparam int unsigned BLOCK_IDX_W = 7;
   // status register field positions
   localparam int unsigned SR_BUSY_POS = 0;
   localparam int unsigned SR_UNLOCK_POS = 1;
   localparam int unsigned SR_BP_LSB = 2;
   localparam int unsigned SR_QUAD_POS = 6;
   localparam int unsigned SR_WDIS_POS = 7;
   localparam logic [7:0] SR_RESET = 8'h00;
   // function register field positions
   localparam int unsigned FR_RSTDIS_POS = 0;
   localparam int unsigned FR_BOTTOM_POS = 1;
   localparam int unsigned FR_PROG_SUSP_POS = 2;
   localparam int unsigned FR_ERASE_SUSP_POS = 3;
   localparam int unsigned FR_IRL_LSB = 4;
   localparam logic [7:0] FR_OTP_MASK = 8'hF3;
   localparam logic [7:0] FR_RESET = 8'h00;
   // optional protection map block counts for codes 8..13
   localparam logic [7:0] OPT_CNT_8 = 8'h60;
   localparam logic [7:0] OPT_CNT_9 = 8'h70;
   localparam logic [7:0] OPT_CNT_10 = 8'h78;
   localparam logic [7:0] OPT_CNT_11 = 8'h7C;
   localparam logic [7:0] OPT_CNT_12 = 8'h7E;
   localparam logic [7:0] OPT_CNT_13 = 8'h7F;
   localparam logic [7:0] ALL_CNT = 8'h80;
endpackage

//--- bench/fwp_monitor.sv
// fwp_monitor: port checks for fwp_core
// assumes the host spaces unlock and command two edges apart
`timescale 1ns/1ns
module fwp_monitor
   import fwp_pkg::*;
#(
   parameter logic OPTIONAL_MAP = 1'b0
)
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic write_unlock_cmd_i,
   input wire logic write_status_cmd_i,
   input wire logic [7:0] status_data_i,
   input wire logic write_protect_pin_i,
   input wire logic whole_array_erase_cmd_i,
   input wire logic info_row_prog_cmd_i,
   input wire logic [1:0] info_row_sel_i,
   input wire logic [7:0] status_reg_o,
   input wire logic [7:0] function_config_o,
   input wire logic op_start_o,
   input wire logic op_rejected_o,
   input wire logic quad_lane_enable_o,
   input wire logic [BLOCK_IDX_W:0] protect_count_o,
   input wire logic protect_bottom_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   function automatic logic [7:0] cnt(input logic [3:0] c);
      if (c[3] && OPTIONAL_MAP)
         return 8'h80 - (8'h20 >> c[2:0]);
      return c == 4'h0 ? 8'h00 : c[3] ? 8'h80 : 8'h01 << (c - 4'h1);
   endfunction
   sequence s_locked;
      write_status_cmd_i && status_reg_o[7] && !write_protect_pin_i;
   endsequence
   sequence s_kept;
      op_rejected_o ##1 status_reg_o[7:2] == $past(status_reg_o[7:2], 2);
   endsequence
   property p_locked;
      s_locked |=> s_kept;
   endproperty
   a_locked: assert property (p_locked)
      else $error("locked status write took effect");
   property p_open;
      write_status_cmd_i && $past(write_unlock_cmd_i, 2) && !status_reg_o[0]
      && (!status_reg_o[7] || write_protect_pin_i)
      |-> ##2 status_reg_o[7:2] == $past(status_data_i[7:2], 2);
   endproperty
   a_open: assert property (p_open)
      else $error("status write not applied");
   property p_erase;
      whole_array_erase_cmd_i && status_reg_o[5:2] != 4'h0 |=> !op_start_o && op_rejected_o;
   endproperty
   a_erase: assert property (p_erase)
      else $error("erase ran with protection set");
   property p_quad;
      $changed(quad_lane_enable_o) |-> quad_lane_enable_o == status_reg_o[6] && $past(write_status_cmd_i, 2);
   endproperty
   a_quad: assert property (p_quad)
      else $error("lane enable does not follow status");
   property p_count;
      status_reg_o[5:2] == $past(status_reg_o[5:2], 3) |-> protect_count_o == cnt(status_reg_o[5:2]);
   endproperty
   a_count: assert property (p_count)
      else $error("protected count wrong");
   property p_otp;
      (($past(function_config_o) & FR_OTP_MASK & ~function_config_o) == 8'h00);
   endproperty
   a_otp: assert property (p_otp)
      else $error("one-time bit returned to zero");
   property p_bottom;
      function_config_o[1] |=> protect_bottom_o && function_config_o[1];
   endproperty
   a_bottom: assert property (p_bottom)
      else $error("bottom select not held");
   property p_row;
      info_row_prog_cmd_i && function_config_o[FR_IRL_LSB + info_row_sel_i] |=> !op_start_o;
   endproperty
   a_row: assert property (p_row)
      else $error("locked row programmed");
endmodule
bind fwp_core fwp_monitor #(.OPTIONAL_MAP(OPTIONAL_MAP)) u_mon (
   .clk_i, .rst_n_i, .write_unlock_cmd_i, .write_status_cmd_i, .status_data_i,
   .write_protect_pin_i, .whole_array_erase_cmd_i, .info_row_prog_cmd_i, .info_row_sel_i,
   .status_reg_o, .function_config_o, .op_start_o, .op_rejected_o,
   .quad_lane_enable_o, .protect_count_o, .protect_bottom_o
);

//--- bench/fwp_host.sv
// fwp_host: host controller model issuing decoded commands
// assumes one clock shared with the device
`timescale 1ns/1ns
module fwp_host
(
   input wire logic clk_i,
   output logic [9:0] cmd_o,
   output logic [7:0] data_o,
   output logic wp_o
);
   initial
   begin
      cmd_o = 10'h000;
      data_o = 8'h00;
      wp_o = 1'b0;
   end
   // released data is inverted so a stale value is never trusted
   task automatic pulse(input int b, input logic [7:0] d);
      @(posedge clk_i);
      cmd_o <= 10'h001 << b;
      data_o <= d;
      @(posedge clk_i);
      cmd_o <= 10'h000;
      data_o <= ~d;
   endtask
   // pins are driven, never tied to supply, so quad lanes may be enabled
   task automatic issue(input int b, input logic [7:0] d);
      pulse(0, 8'h00);
      pulse(b, d);
   endtask
   task automatic pin(input logic v);
      @(posedge clk_i);
      wp_o <= v;
   endtask
endmodule

//--- bench/tb.sv
// tb: directed checks of fwp_core through the host model
// assumes the standard protection map and a zero reset strap
`timescale 1ns/1ns
module tb
   import fwp_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [9:0] cmd;
   logic [7:0] dat, sr, fr, pc;
   logic wp, st, rj, qle, rh, pb;
   int num_errors = 0;
   int checks = 0;
   always #4 clk_i = ~clk_i;
   fwp_host u_host (.clk_i, .cmd_o(cmd), .data_o(dat), .wp_o(wp));
   fwp_core uut (
      .clk_i, .rst_n_i, .write_unlock_cmd_i(cmd[0]), .write_lock_cmd_i(cmd[1]),
      .write_status_cmd_i(cmd[2]), .status_data_i(dat), .write_function_cmd_i(cmd[3]),
      .function_data_i(dat), .write_protect_pin_i(wp), .whole_array_erase_cmd_i(cmd[4]),
      .array_op_cmd_i(cmd[5]), .array_op_is_erase_i(dat[7]), .array_op_first_block_i(dat[6:0]),
      .array_op_last_block_i(dat[6:0]), .info_row_prog_cmd_i(cmd[6]), .info_row_sel_i(dat[1:0]),
      .op_done_i(cmd[7]), .suspend_cmd_i(cmd[8]), .resume_cmd_i(cmd[9]), .status_reg_o(sr),
      .function_config_o(fr), .op_start_o(st), .op_rejected_o(rj), .quad_lane_enable_o(qle),
      .reset_on_hold_pin_o(rh), .protect_count_o(pc), .protect_bottom_o(pb)
   );
   task automatic report_and_stop();
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // unlocked command, its answer, then completion and a settle gap
   task automatic run(input int b, input logic [7:0] d, input logic [1:0] ans);
      // the answer stands only in the cycle after the command edge
      u_host.issue(b, d);
      #1;
      chk({6'h00, st, rj}, {6'h00, ans});
      u_host.pulse(7, 8'h00);
      repeat (4) @(posedge clk_i);
      #1;
   endtask
   task automatic susp(input logic [7:0] d, input logic [7:0] flag);
      u_host.issue(5, d);
      u_host.pulse(8, 8'h00);
      repeat (2) @(posedge clk_i);
      #1;
      chk(fr, 8'h13 | flag);
      u_host.pulse(9, 8'h00);
      repeat (2) @(posedge clk_i);
      #1;
      chk(fr, 8'h13);
      u_host.pulse(7, 8'h00);
      repeat (4) @(posedge clk_i);
   endtask
   initial
   begin
      #20000;
      num_errors++;
      report_and_stop();
   end
   initial
   begin
      repeat (8) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      #1;
      chk(sr, SR_RESET);
      chk(fr, FR_RESET);
      for (int c = 0; c < 16; c++)
      begin
         run(2, {2'b00, c[3:0], 2'b00}, 2'b00);
         chk(pc, c == 0 ? 8'h00 : c > 7 ? 8'h80 : 8'h01 << (c - 1));
      end
      // status write with the latch clear, then after unlock and lock
      u_host.pulse(2, 8'h00);
      #1;
      chk({6'h00, st, rj}, 8'h01);
      u_host.pulse(0, 8'h00);
      u_host.pulse(1, 8'h00);
      u_host.pulse(2, 8'h00);
      #1;
      chk({6'h00, st, rj}, 8'h01);
      chk(pc, ALL_CNT);
      run(4, 8'h00, 2'b01);
      run(5, 8'h85, 2'b01);
      run(2, 8'h00, 2'b00);
      run(4, 8'h00, 2'b10);
      run(2, 8'hC4, 2'b00);
      chk({sr[7:2], qle, rh}, 8'hC6);
      run(2, 8'h00, 2'b01);
      chk({sr[7:2], 2'b00}, 8'hC4);
      u_host.pin(1'b1);
      run(2, 8'h08, 2'b00);
      chk({sr[7:2], qle, pc[0]}, 8'h08);
      run(3, 8'h12, 2'b00);
      chk(fr, 8'h12);
      run(3, 8'h00, 2'b00);
      chk({fr[7:1], pb}, 8'h13);
      run(5, 8'h01, 2'b01);
      run(5, 8'h02, 2'b10);
      run(6, 8'h00, 2'b01);
      run(6, 8'h01, 2'b10);
      run(3, 8'h01, 2'b00);
      chk({7'h00, rh}, 8'h01);
      susp(8'h05, 8'h04);
      susp(8'h86, 8'h08);
      report_and_stop();
   end
endmodule
